// file: src/qrx_pkg.sv
package qrx_pkg;

  // ==========================================
  // Control word layout
  localparam int unsigned WORD_BITS = 32;
  localparam logic [31:0] POR_WORD  = 32'h0000_cc00;

  localparam int unsigned BIT_EN_B       = 0;
  localparam int unsigned BIT_B_AMP1_LO  = 1;
  localparam int unsigned BIT_B_AMP2_LO  = 3;
  localparam int unsigned BIT_TEST_LO    = 6;
  localparam int unsigned BIT_FACTORY_LO = 10;
  localparam int unsigned BIT_EN_A       = 16;
  localparam int unsigned BIT_A_AMP1_LO  = 17;
  localparam int unsigned BIT_A_AMP2_LO  = 19;
  localparam int unsigned BIT_SEL_LO     = 22;
  localparam int unsigned BIT_FLOAT      = 25;
  localparam int unsigned BIT_TRIM3      = 26;
  localparam int unsigned BIT_PROBE_LO   = 27;
  localparam int unsigned BIT_TRIM_LO    = 29;

  // ==========================================
  // Timing
  localparam int unsigned CLK_PS        = 4000;
  localparam int unsigned DOUT_START_NS = 90;
  localparam int unsigned DOUT_SHIFT_NS = 30;
  localparam int unsigned DOUT_REL_NS   = 100;
  localparam int unsigned GAP_US        = 5;
  // Longest times round down
  localparam int unsigned DOUT_SHIFT_CYC = DOUT_SHIFT_NS * 1000 / CLK_PS;
  localparam int unsigned GAP_CYC        = GAP_US * 1000000 / CLK_PS;
  // Input sync (2) plus edge detect (1) plus output register (1)
  localparam int unsigned PIPE_CYC       = 4;

  // ==========================================
  // Analog selector codes
  localparam logic [2:0] SEL_TEMP0 = 3'h0;
  localparam logic [2:0] SEL_TEMP1 = 3'h1;
  localparam logic [2:0] SEL_PROBE = 3'h2;
  localparam logic [2:0] SEL_BGAP  = 3'h4;
  localparam logic [1:0] PROBE_LO_POWER = 2'h0;

  typedef struct packed {
    logic       en;
    logic [1:0] amp1_gain;   // [0]=6 dB, [1]=12 dB
    logic [2:0] amp2_gain;   // [0]=6, [1]=12, [2]=18 dB
  } qrx_pair_s;

  typedef struct packed {
    logic       route_temp;
    logic       route_probe;
    logic       route_bgap;
    logic       probe_lo_power;
    logic       flag_drive;
    logic       analog_drive;
  } qrx_mux_s;

endpackage

// file: src/qrx_spi_slave.sv
`timescale 1ns/1ps

// What this block does
// - Power-on preset: bits 10, 11, 14, 15 high, others low.
// - Falling serial select starts a new command frame.
// - Serial input sampled on each falling serial clock edge.
// - Word shifted in most significant bit first, bit 31 to 0.
// - Bit 0 enables receivers three and four.
// - Bit 16 enables receivers one and two.
// - Bits 1-5 set gain stages for receivers three and four.
// - Bits 17-21 set gain stages for receivers one and two.
// - Bits 6-9 inject test signal into channels four to one.
// - Bits 24..22 form the analog selector, bit 24 most significant.
// - Bit 25 floats the flag output and lets selector drive pin.
// - Bits 28..27 pick probe; only code 00 gives LO power.
// - Selector 00X routes temperature sensor.
// - Selector 010 routes chosen probe, 100 the band gap.
// - Other selector codes leave the analog output unselected.
// - Output drives word MSB within 90 ns of select falling.
// - Next output bit within 30 ns of each falling clock edge.
// - Output released within 100 ns of select rising.
// - All saturation detections OR into one flag.
// - Flag and analog signal share one pin, chosen by bit 25.
module qrx_spi_slave (
  input  wire logic               clock,            // 250 MHz system clock
  input  wire logic               nrst,             // Synchronous reset, active low
  input  wire logic               serial_select_n,  // Frame select pin, active low
  input  wire logic               serial_clock,     // Serial clock pin
  input  wire logic               serial_in,        // Serial data pin
  input  wire logic [7:0]         sat_detect,       // Mixer and IF saturation detectors
  output logic                    serial_out,       // Serial data out
  output logic                    serial_out_oe,    // Serial data out enable
  output qrx_pkg::qrx_pair_s      pair_a,           // Receivers one and two
  output qrx_pkg::qrx_pair_s      pair_b,           // Receivers three and four
  output logic [3:0]              test_inject,      // [0]=ch1 .. [3]=ch4
  output logic [9:0]              factory_bits,     // Bits 10..15, 26, 29..31
  output qrx_pkg::qrx_mux_s       mux,              // Analog selector decode
  output logic                    analog_flag_pin,  // Flag level on shared pin
  output logic                    analog_flag_oe,   // Flag drives shared pin
  output logic                    frame_error       // Last frame not 32 edges
);

  // ==========================================
  // State
  typedef struct packed {
    logic [1:0]  sel_sync;
    logic [1:0]  sck_sync;
    logic [1:0]  din_sync;
    logic        sel_q;
    logic        sck_q;
    logic        busy;
    logic [5:0]  count;
    logic [31:0] shift;
    logic [31:0] word;
    logic [31:0] out_shift;
    logic        dout;
    logic        doe;
    logic        flag;
    logic        err;
  } qrx_state_s;

  qrx_state_s st;
  qrx_state_s next_st;
  logic       sel_fall;
  logic       sel_rise;
  logic       sck_fall;

  always_comb begin
    next_st          = st;
    next_st.sel_sync = {st.sel_sync[0], serial_select_n};
    next_st.sck_sync = {st.sck_sync[0], serial_clock};
    next_st.din_sync = {st.din_sync[0], serial_in};
    next_st.sel_q    = st.sel_sync[1];
    next_st.sck_q    = st.sck_sync[1];
    sel_fall = st.sel_q & ~st.sel_sync[1];
    sel_rise = ~st.sel_q & st.sel_sync[1];
    sck_fall = st.sck_q & ~st.sck_sync[1] & ~st.sel_sync[1];
    if (sel_fall) begin
      next_st.busy      = 1'b1;
      next_st.count     = 6'h00;
      next_st.out_shift = st.word;
      next_st.dout      = st.word[31];
      next_st.doe       = 1'b1;
    end else if (st.busy && sck_fall) begin
      next_st.shift = {st.shift[30:0], st.din_sync[1]};
      if (st.count != 6'h3f) begin
        next_st.count = st.count + 6'h01;
      end
      next_st.out_shift = {st.out_shift[30:0], 1'b0};
      next_st.dout      = st.out_shift[30];
    end
    if (sel_rise) begin
      next_st.doe  = 1'b0;
      next_st.busy = 1'b0;
      if (st.busy && st.count == 6'(qrx_pkg::WORD_BITS)) begin
        next_st.word = st.shift;
        next_st.err  = 1'b0;
      end else if (st.busy) begin
        next_st.err  = 1'b1;
      end
    end
    next_st.flag = |sat_detect;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st          <= '0;
      // Pins idle high; matching them avoids a false edge after reset
      st.sel_sync <= 2'h3;
      st.sck_sync <= 2'h3;
      st.din_sync <= 2'h3;
      st.sel_q    <= 1'b1;
      st.sck_q    <= 1'b1;
      st.word     <= qrx_pkg::POR_WORD;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Control word fields
  // Pair three/four, then pair one/two
  assign pair_b.en        = st.word[qrx_pkg::BIT_EN_B];
  assign pair_b.amp1_gain = st.word[qrx_pkg::BIT_B_AMP1_LO +: 2];
  assign pair_b.amp2_gain = st.word[qrx_pkg::BIT_B_AMP2_LO +: 3];
  assign pair_a.en        = st.word[qrx_pkg::BIT_EN_A];
  assign pair_a.amp1_gain = st.word[qrx_pkg::BIT_A_AMP1_LO +: 2];
  assign pair_a.amp2_gain = st.word[qrx_pkg::BIT_A_AMP2_LO +: 3];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_inj
      assign test_inject[gi] = st.word[qrx_pkg::BIT_TEST_LO + 3 - gi];
    end
  endgenerate

  assign factory_bits = {st.word[qrx_pkg::BIT_TRIM_LO +: 3],
                         st.word[qrx_pkg::BIT_TRIM3],
                         st.word[qrx_pkg::BIT_FACTORY_LO +: 6]};

  // ==========================================
  // Analog selector decode
  logic [2:0] sel_code;
  logic [1:0] probe_code;
  logic       flt;
  assign sel_code   = st.word[qrx_pkg::BIT_SEL_LO +: 3];
  assign probe_code = st.word[qrx_pkg::BIT_PROBE_LO +: 2];
  assign flt        = st.word[qrx_pkg::BIT_FLOAT];

  always_comb begin
    mux = '0;
    unique case (sel_code)
      qrx_pkg::SEL_TEMP0, qrx_pkg::SEL_TEMP1: mux.route_temp  = 1'b1;
      qrx_pkg::SEL_PROBE:                     mux.route_probe = 1'b1;
      qrx_pkg::SEL_BGAP:                      mux.route_bgap  = 1'b1;
      default: ;
    endcase
    mux.probe_lo_power = (probe_code == qrx_pkg::PROBE_LO_POWER);
    mux.flag_drive     = ~flt;
    mux.analog_drive   = flt;
  end

  assign analog_flag_pin = st.flag;
  assign analog_flag_oe  = ~flt;
  assign serial_out      = st.dout;
  assign serial_out_oe   = st.doe;
  assign frame_error     = st.err;

  // ==========================================
  // Checks
  logic [31:0] last_word;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      last_word <= qrx_pkg::POR_WORD;
    end else begin
      last_word <= st.word;
    end
  end

  property p_por;
    @(posedge clock) $rose(nrst) |-> st.word == 32'h0000_cc00;
  endproperty
  a_por: assert property (p_por) else $error("bad preset");

  property p_start;
    @(posedge clock) disable iff (!nrst)
      sel_fall |=> serial_out_oe && serial_out == st.out_shift[31] && st.busy;
  endproperty
  a_start: assert property (p_start) else $error("frame start wrong");

  property p_shift;
    @(posedge clock) disable iff (!nrst)
      (st.busy && sck_fall && !sel_fall) |=> st.shift[0] == $past(st.din_sync[1]);
  endproperty
  a_shift: assert property (p_shift) else $error("sample lost");

  property p_msb;
    @(posedge clock) disable iff (!nrst)
      (st.busy && sck_fall && !sel_fall) |=> st.shift[31:1] == $past(st.shift[30:0]);
  endproperty
  a_msb: assert property (p_msb) else $error("shift order wrong");

  property p_enables;
    @(posedge clock) disable iff (!nrst)
      pair_b.en == st.word[0] && pair_a.en == st.word[16];
  endproperty
  a_enables: assert property (p_enables) else $error("enable map wrong");

  property p_inject;
    @(posedge clock) disable iff (!nrst)
      test_inject[3] == st.word[6] && test_inject[0] == st.word[9];
  endproperty
  a_inject: assert property (p_inject) else $error("inject map wrong");

  property p_mux;
    @(posedge clock) disable iff (!nrst)
      (sel_code == 3'h1) |-> mux.route_temp && !mux.route_probe && !mux.route_bgap;
  endproperty
  a_mux: assert property (p_mux) else $error("selector 001 wrong");

  property p_undef;
    @(posedge clock) disable iff (!nrst)
      (sel_code == 3'h3 || sel_code > 3'h4) |-> !(mux.route_temp | mux.route_probe | mux.route_bgap);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined code routed");

  property p_release;
    @(posedge clock) disable iff (!nrst)
      sel_rise |=> !serial_out_oe;
  endproperty
  a_release: assert property (p_release) else $error("output not released");

  property p_flag;
    @(posedge clock) disable iff (!nrst)
      (|sat_detect) |=> analog_flag_pin;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");

  property p_pin;
    @(posedge clock) disable iff (!nrst)
      analog_flag_oe != mux.analog_drive && analog_flag_oe == !st.word[25];
  endproperty
  a_pin: assert property (p_pin) else $error("pin owner wrong");

  property p_apply;
    @(posedge clock) disable iff (!nrst)
      (st.word != last_word) |-> $past(sel_rise) && $past(st.count) == 6'd32;
  endproperty
  a_apply: assert property (p_apply) else $error("word changed mid frame");

  // ==========================================
  // Pin-level timing
  // Bounds are pin limits over the 4 ns period, rounded down
  sequence s_pin_open;
    $fell(serial_select_n);
  endsequence

  sequence s_msb_shown;
    serial_out_oe && serial_out == st.word[31];
  endsequence

  sequence s_link_fall;
    $fell(serial_clock) && !serial_select_n;
  endsequence

  sequence s_bit_taken;
    st.busy && sck_fall;
  endsequence

  sequence s_next_bit;
    serial_out_oe && serial_out == $past(st.out_shift[30]);
  endsequence

  property p_lead;
    @(posedge clock) disable iff (!nrst)
      s_pin_open |-> ##[1:22] s_msb_shown;
  endproperty
  a_lead: assert property (p_lead) else $error("first bit late after select");

  property p_bit_lat;
    @(posedge clock) disable iff (!nrst)
      s_link_fall |-> ##[1:6] s_bit_taken ##1 s_next_bit;
  endproperty
  a_bit_lat: assert property (p_bit_lat) else $error("next bit late");

  property p_float_late;
    @(posedge clock) disable iff (!nrst)
      $rose(serial_select_n) |-> ##[1:25] !serial_out_oe;
  endproperty
  a_float_late: assert property (p_float_late) else $error("output released late");

  // ==========================================
  // Frame acceptance
  property p_good;
    @(posedge clock) disable iff (!nrst)
      (sel_rise && st.busy && st.count == 6'd32)
        |=> !frame_error && st.word == $past(st.shift);
  endproperty
  a_good: assert property (p_good) else $error("good frame not applied");

  property p_reject;
    @(posedge clock) disable iff (!nrst)
      (sel_rise && st.busy && st.count != 6'd32)
        |=> frame_error && st.word == $past(st.word);
  endproperty
  a_reject: assert property (p_reject) else $error("short or long frame applied");

  property p_idle;
    @(posedge clock) disable iff (!nrst)
      (!st.busy && !sel_fall) |=> $stable(st.shift);
  endproperty
  a_idle: assert property (p_idle) else $error("bit taken outside frame");

  // ==========================================
  // Flag and selector decode
  property p_flag_low;
    @(posedge clock) disable iff (!nrst)
      !(|sat_detect) |=> !analog_flag_pin;
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("flag set without detect");

  property p_probe;
    @(posedge clock) disable iff (!nrst)
      mux.probe_lo_power == (st.word[28:27] == 2'h0);
  endproperty
  a_probe: assert property (p_probe) else $error("probe decode wrong");

  property p_probe_route;
    @(posedge clock) disable iff (!nrst)
      (sel_code == 3'h2) |-> mux.route_probe && !mux.route_temp && !mux.route_bgap;
  endproperty
  a_probe_route: assert property (p_probe_route) else $error("selector 010 wrong");

  property p_bgap;
    @(posedge clock) disable iff (!nrst)
      (sel_code == 3'h4) |-> mux.route_bgap && !mux.route_temp && !mux.route_probe;
  endproperty
  a_bgap: assert property (p_bgap) else $error("selector 100 wrong");

endmodule

// file: testbench/qrx_host_model.sv
`timescale 1ns/1ps

module qrx_host_model (
  output logic      serial_select_n, // Frame select, idles high
  output logic      serial_clock,    // Link clock, stands high outside frames
  output logic      serial_in,       // Data to device
  input  wire logic serial_out,      // Data from device
  input  wire logic serial_out_oe    // Device drives serial_out
);
  logic [31:0] rd;     // First 32 bits read back
  logic        rd_oe;  // Enable seen at every read bit

  initial begin
    serial_select_n = 1'b1;
    serial_clock    = 1'b1;
    serial_in       = 1'b1;
    rd              = 32'h0000_0000;
    rd_oe           = 1'b0;
  end

  // ==========================================
  // One frame of n bits, 80 ns link period
  task automatic send(input logic [39:0] w, input int n);
    serial_select_n = 1'b0;
    rd_oe = 1'b1;
    #20;
    for (int i = 0; i < n; i++) begin
      serial_in = w[n-1-i];
      #20;
      if (i < 32) begin
        rd = {rd[30:0], serial_out};
        rd_oe = rd_oe & serial_out_oe;
      end
      #20 serial_clock = 1'b0;
      #40 serial_clock = 1'b1;
    end
    #40 serial_select_n = 1'b1;
    // Pull-up lifts the released line
    serial_in = 1'b1;
    #(qrx_pkg::GAP_US * 1000);
  endtask
endmodule

// file: testbench/qrx_spi_slave_tb.sv
`timescale 1ns/1ps

module qrx_spi_slave_tb;
  logic               clock;
  logic               nrst;
  logic [7:0]         sat_detect;
  logic               serial_select_n;
  logic               serial_clock;
  logic               serial_in;
  logic               serial_out;
  logic               serial_out_oe;
  qrx_pkg::qrx_pair_s pair_a;
  qrx_pkg::qrx_pair_s pair_b;
  logic [3:0]         test_inject;
  logic [9:0]         factory_bits;
  qrx_pkg::qrx_mux_s  mux;
  logic               analog_flag_pin;
  logic               analog_flag_oe;
  logic               frame_error;
  logic [33:0]        outs;
  logic [31:0]        cur;
  logic [31:0]        w;
  int                 n_errors;
  int                 checks_done;

  assign outs = {pair_a, pair_b, test_inject, factory_bits, mux, analog_flag_oe, frame_error};

  qrx_spi_slave qrx_spi_slave_inst (.clock(clock), .nrst(nrst),
    .serial_select_n(serial_select_n), .serial_clock(serial_clock), .serial_in(serial_in),
    .sat_detect(sat_detect), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .pair_a(pair_a), .pair_b(pair_b), .test_inject(test_inject),
    .factory_bits(factory_bits), .mux(mux), .analog_flag_pin(analog_flag_pin),
    .analog_flag_oe(analog_flag_oe), .frame_error(frame_error));

  qrx_host_model qrx_host_model_inst (.serial_select_n(serial_select_n),
    .serial_clock(serial_clock), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe));

  // ==========================================
  // Expected field outputs of a stored word
  function automatic logic [33:0] exp_out(input logic [31:0] v, input logic err);
    logic [2:0] s;
    s = v[24:22];
    return {v[16], v[18:17], v[21:19], v[0], v[2:1], v[5:3], v[6], v[7], v[8], v[9],
            v[31:29], v[26], v[15:10], s[2:1] == 2'h0, s == qrx_pkg::SEL_PROBE,
            s == qrx_pkg::SEL_BGAP, v[28:27] == qrx_pkg::PROBE_LO_POWER,
            ~v[25], v[25], ~v[25], err};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic [39:0] v, input int n);
    logic bad;
    bad = (n != 32);
    qrx_host_model_inst.send(v, n);
    chk(serial_out_oe, 1'b0);
    if (!bad) begin
      chk({qrx_host_model_inst.rd_oe, qrx_host_model_inst.rd}, {1'b1, cur});
      cur = v[31:0];
    end
    chk(outs, exp_out(cur, bad));
  endtask

  task final_report;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Whole run takes about 122 us
  initial begin
    #300000;
    n_errors++;
    final_report;
  end

  initial begin
    n_errors = 0;
    checks_done = 0;
    nrst = 1'b0;
    sat_detect = 8'h00;
    cur = qrx_pkg::POR_WORD;
    void'($urandom(40));
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    chk(outs, exp_out(cur, 1'b0));
    // Every selector and probe code, then all ones and all zeros
    for (int i = 0; i < 12; i++) begin
      w = $urandom;
      if (i < 8) begin
        w[24:22] = i[2:0];
        w[27] = i[0];
        w[28] = i[1];
      end
      if (i == 8) w = 32'hffff_ffff;
      if (i == 9) w = 32'h0000_0000;
      frame({8'h00, w}, 32);
    end
    frame({8'h00, $urandom}, 31);
    frame({8'h00, $urandom}, 32);
    frame({7'h00, 1'b1, $urandom}, 33);
    for (int i = 0; i < 40; i++) begin
      @(negedge clock);
      chk(analog_flag_pin, |sat_detect);
      sat_detect = i[1] ? 8'h00 : 8'(1 << $urandom_range(7, 0));
    end
    // Second reset in mid-run restores the preset and clears the error
    nrst = 1'b0;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    cur = qrx_pkg::POR_WORD;
    repeat (4) @(negedge clock);
    chk(outs, exp_out(cur, 1'b0));
    frame({8'h00, $urandom}, 32);
    final_report;
  end
endmodule
